// file: rtl/irf_top.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irf_consts.svh"
module irf_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_direct_transition,
    input wire logic direct_transition_enable,
    input wire logic rtc_overflow,
    input wire logic timer_b_overflow,
    input wire logic [3:0] ext_request_pin,
    output logic irq
);
    irf_bus_if bus ();

    irf_pkg::irf_byte_t flags1_ff;
    irf_pkg::irf_byte_t flags2_ff;
    irf_pkg::irf_byte_t en1_ff;
    irf_pkg::irf_byte_t en2_ff;
    logic [3:0] edge_ff;
    logic [3:0] func_ff;
    logic irq_ff;
    irf_pkg::irf_byte_t set1;
    irf_pkg::irf_byte_t set2;
    irf_pkg::irf_byte_t clr1;
    irf_pkg::irf_byte_t clr2;
    irf_pkg::irf_byte_t nxt_flags1;
    irf_pkg::irf_byte_t nxt_flags2;
    logic [3:0] pin_evt;
    logic dt_set;
    logic wr_f1;
    logic wr_f2;

    irf_apb_slave u_apb (
        .clk(clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .bus(bus.slave),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    irf_pin_edge u_pins (
        .clk(clk),
        .rst(rst),
        .pin(ext_request_pin),
        .edge_rising(edge_ff),
        .pin_enable(func_ff),
        .evt(pin_evt)
    );

    assign dt_set = sleep_direct_transition & direct_transition_enable;
    assign wr_f1 = bus.wr & (bus.sel == irf_pkg::IRF_SEL_FLAGS1);
    assign wr_f2 = bus.wr & (bus.sel == irf_pkg::IRF_SEL_FLAGS2);

    // hardware set events per flag
    always_comb begin
        set1 = 8'h00;
        set1[`IRF_BIT_DT] = dt_set;
        set1[`IRF_BIT_RTC] = rtc_overflow;
        set1[`IRF_PIN_HI:0] = pin_evt;
        set2 = 8'h00;
        set2[`IRF_BIT_TB] = timer_b_overflow;
    end

    // only written zeros clear; set wins over clear
    always_comb begin
        clr1 = wr_f1 ? (~bus.wdata & `IRF_MASK_1) : 8'h00;
        clr2 = wr_f2 ? (~bus.wdata & `IRF_MASK_2) : 8'h00;
        nxt_flags1 = ((flags1_ff & ~clr1) | set1) & `IRF_MASK_1;
        nxt_flags2 = ((flags2_ff & ~clr2) | set2) & `IRF_MASK_2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags1_ff <= `IRF_RST_FLAGS;
        end else begin
            flags1_ff <= nxt_flags1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags2_ff <= `IRF_RST_FLAGS;
        end else begin
            flags2_ff <= nxt_flags2;
        end
    end

    // enable registers
    always_ff @(posedge clk) begin
        if (rst) begin
            en1_ff <= `IRF_RST_CTRL;
            en2_ff <= `IRF_RST_CTRL;
        end else if (bus.wr) begin
            if (bus.sel == irf_pkg::IRF_SEL_EN1) begin
                en1_ff <= bus.wdata & `IRF_MASK_1;
            end
            if (bus.sel == irf_pkg::IRF_SEL_EN2) begin
                en2_ff <= bus.wdata & `IRF_MASK_2;
            end
        end
    end

    // edge select and pin function
    always_ff @(posedge clk) begin
        if (rst) begin
            edge_ff <= `IRF_RST_SEL;
            func_ff <= `IRF_RST_SEL;
        end else if (bus.wr) begin
            if (bus.sel == irf_pkg::IRF_SEL_EDGE) begin
                edge_ff <= bus.wdata[3:0];
            end
            if (bus.sel == irf_pkg::IRF_SEL_FUNC) begin
                func_ff <= bus.wdata[3:0];
            end
        end
    end

    // interrupt only from enabled flags
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(flags1_ff & en1_ff) | |(flags2_ff & en2_ff);
        end
    end
    assign irq = irq_ff;

    // read mux with reserved constants
    always_comb begin
        case (bus.sel)
            irf_pkg::IRF_SEL_FLAGS1: bus.rdata = flags1_ff | `IRF_ONES_1;
            irf_pkg::IRF_SEL_FLAGS2: bus.rdata = flags2_ff | `IRF_ONES_2;
            irf_pkg::IRF_SEL_EN1: bus.rdata = en1_ff | `IRF_ONES_1;
            irf_pkg::IRF_SEL_EN2: bus.rdata = en2_ff | `IRF_ONES_2;
            irf_pkg::IRF_SEL_EDGE: bus.rdata = {4'h0, edge_ff};
            irf_pkg::IRF_SEL_FUNC: bus.rdata = {4'h0, func_ff};
            default: bus.rdata = 8'h00;
        endcase
    end

    logic rd_done;
    assign rd_done = pready & psel & penable & ~pwrite & ~pslverr;

    a_dt_flag_set: assert property (@(posedge clk) disable iff (rst)
        dt_set |=> flags1_ff[`IRF_BIT_DT])
        else $error("direct transition flag not set");
    a_dt_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(flags1_ff[`IRF_BIT_DT]) |-> $past(sleep_direct_transition && direct_transition_enable))
        else $error("direct transition flag set without cause");
    a_rtc_flag_set: assert property (@(posedge clk) disable iff (rst)
        rtc_overflow |=> flags1_ff[`IRF_BIT_RTC])
        else $error("rtc flag not set");
    a_pin_flag_set: assert property (@(posedge clk) disable iff (rst)
        pin_evt[0] |=> flags1_ff[0])
        else $error("pin 0 flag not set");
    a_pin_needs_func: assert property (@(posedge clk) disable iff (rst)
        $rose(flags1_ff[1]) |-> $past(func_ff[1]))
        else $error("pin 1 flag set while pin not an interrupt input");
    a_tb_flag_set: assert property (@(posedge clk) disable iff (rst)
        timer_b_overflow |=> flags2_ff[`IRF_BIT_TB])
        else $error("timer b flag not set");
    a_flag_clear_cause: assert property (@(posedge clk) disable iff (rst)
        $fell(flags1_ff[`IRF_BIT_RTC]) |-> $past(wr_f1 && !pwdata[`IRF_BIT_RTC]))
        else $error("flag cleared without a zero write");
    a_write_one_keeps: assert property (@(posedge clk) disable iff (rst)
        wr_f2 && pwdata[`IRF_BIT_TB] && flags2_ff[`IRF_BIT_TB] |=> flags2_ff[`IRF_BIT_TB])
        else $error("writing one cleared a flag");
    a_rsv_one_read: assert property (@(posedge clk) disable iff (rst)
        rd_done && paddr == `IRF_OFF_FLAGS1 |-> prdata[5:4] == 2'b11 && prdata[31:8] == 24'h0)
        else $error("reserved ones of register one misread");
    a_rsv_two_read: assert property (@(posedge clk) disable iff (rst)
        rd_done && paddr == `IRF_OFF_FLAGS2 |-> prdata[7:6] == 2'b00 && prdata[4:0] == 5'h1f)
        else $error("reserved bits of register two misread");
    a_reset_clear: assert property (@(posedge clk)
        rst |=> flags1_ff == 8'h00 && flags2_ff == 8'h00 && !irq)
        else $error("flags not cleared by reset");
    a_irq_gate: assert property (@(posedge clk) disable iff (rst)
        irq |-> $past((flags1_ff & en1_ff) != 8'h00 || (flags2_ff & en2_ff) != 8'h00))
        else $error("interrupt without enabled flag");
    a_irq_raise: assert property (@(posedge clk) disable iff (rst)
        (flags1_ff & en1_ff) != 8'h00 |=> irq)
        else $error("enabled flag did not raise interrupt");
    a_set_wins: assert property (@(posedge clk) disable iff (rst)
        rtc_overflow && wr_f1 && !pwdata[`IRF_BIT_RTC] |=> flags1_ff[`IRF_BIT_RTC])
        else $error("clear beat a simultaneous set");

    // per pin flag checks
    for (genvar p = 0; p < 4; p++) begin : g_pin_chk
        a_pin_set_each: assert property (@(posedge clk) disable iff (rst)
            pin_evt[p] |=> flags1_ff[p])
            else $error("pin flag not set by its edge");
        a_pin_cause_each: assert property (@(posedge clk) disable iff (rst)
            $rose(flags1_ff[p]) |-> $past(pin_evt[p]))
            else $error("pin flag set without an edge");
        a_pin_refused: assert property (@(posedge clk) disable iff (rst)
            !func_ff[p] |-> !pin_evt[p])
            else $error("edge taken on a pin not used for requests");
        a_pin_clear_cause: assert property (@(posedge clk) disable iff (rst)
            $fell(flags1_ff[p]) |-> $past(wr_f1 && !bus.wdata[p]))
            else $error("pin flag cleared without a zero write");
        a_pin_zero_clears: assert property (@(posedge clk) disable iff (rst)
            wr_f1 && !bus.wdata[p] && !pin_evt[p] |=> !flags1_ff[p])
            else $error("zero write left a pin flag set");
        a_pin_write_one: assert property (@(posedge clk) disable iff (rst)
            wr_f1 && bus.wdata[p] && flags1_ff[p] |=> flags1_ff[p])
            else $error("one written to a pin flag cleared it");
        a_pin_set_wins: assert property (@(posedge clk) disable iff (rst)
            pin_evt[p] && wr_f1 && !bus.wdata[p] |=> flags1_ff[p])
            else $error("clear beat a pin edge");
        a_pin_irq: assert property (@(posedge clk) disable iff (rst)
            flags1_ff[p] && en1_ff[p] |=> irq)
            else $error("enabled pin flag did not raise interrupt");
    end

    // flag causes and clears
    a_rtc_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(flags1_ff[`IRF_BIT_RTC]) |-> $past(rtc_overflow))
        else $error("rtc flag set without overflow");
    a_tb_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(flags2_ff[`IRF_BIT_TB]) |-> $past(timer_b_overflow))
        else $error("timer b flag set without overflow");
    a_dt_refused: assert property (@(posedge clk) disable iff (rst)
        sleep_direct_transition && !direct_transition_enable && !flags1_ff[`IRF_BIT_DT]
            |=> !flags1_ff[`IRF_BIT_DT])
        else $error("direct transition flag set while disabled");
    a_dt_clear_cause: assert property (@(posedge clk) disable iff (rst)
        $fell(flags1_ff[`IRF_BIT_DT]) |-> $past(wr_f1 && !bus.wdata[`IRF_BIT_DT]))
        else $error("direct transition flag cleared without a zero write");
    a_tb_clear_cause: assert property (@(posedge clk) disable iff (rst)
        $fell(flags2_ff[`IRF_BIT_TB]) |-> $past(wr_f2 && !bus.wdata[`IRF_BIT_TB]))
        else $error("timer b flag cleared without a zero write");
    a_dt_zero_clears: assert property (@(posedge clk) disable iff (rst)
        wr_f1 && !bus.wdata[`IRF_BIT_DT] && !dt_set |=> !flags1_ff[`IRF_BIT_DT])
        else $error("zero write left direct transition flag set");
    a_rtc_zero_clears: assert property (@(posedge clk) disable iff (rst)
        wr_f1 && !bus.wdata[`IRF_BIT_RTC] && !rtc_overflow |=> !flags1_ff[`IRF_BIT_RTC])
        else $error("zero write left rtc flag set");
    a_tb_zero_clears: assert property (@(posedge clk) disable iff (rst)
        wr_f2 && !bus.wdata[`IRF_BIT_TB] && !timer_b_overflow |=> !flags2_ff[`IRF_BIT_TB])
        else $error("zero write left timer b flag set");
    a_dt_write_one: assert property (@(posedge clk) disable iff (rst)
        wr_f1 && bus.wdata[`IRF_BIT_DT] && flags1_ff[`IRF_BIT_DT]
            |=> flags1_ff[`IRF_BIT_DT])
        else $error("one written to direct transition flag cleared it");
    a_rtc_write_one: assert property (@(posedge clk) disable iff (rst)
        wr_f1 && bus.wdata[`IRF_BIT_RTC] && flags1_ff[`IRF_BIT_RTC]
            |=> flags1_ff[`IRF_BIT_RTC])
        else $error("one written to rtc flag cleared it");
    a_flag_hold: assert property (@(posedge clk) disable iff (rst)
        !wr_f1 && set1 == 8'h00 |=> $stable(flags1_ff))
        else $error("register one flags moved without cause");
    a_flag2_hold: assert property (@(posedge clk) disable iff (rst)
        !wr_f2 && set2 == 8'h00 |=> $stable(flags2_ff))
        else $error("register two flags moved without cause");
    a_dt_set_wins: assert property (@(posedge clk) disable iff (rst)
        dt_set && wr_f1 && !bus.wdata[`IRF_BIT_DT] |=> flags1_ff[`IRF_BIT_DT])
        else $error("clear beat a direct transition");
    a_tb_set_wins: assert property (@(posedge clk) disable iff (rst)
        timer_b_overflow && wr_f2 && !bus.wdata[`IRF_BIT_TB] |=> flags2_ff[`IRF_BIT_TB])
        else $error("clear beat a timer b overflow");

    // reserved bits and register reads
    a_rsv_flags_zero: assert property (@(posedge clk) disable iff (rst)
        (flags1_ff & ~`IRF_MASK_1) == 8'h00 && (flags2_ff & ~`IRF_MASK_2) == 8'h00)
        else $error("reserved flag bit stored");
    a_read_flags_one: assert property (@(posedge clk) disable iff (rst)
        rd_done && paddr == `IRF_OFF_FLAGS1
            |-> prdata[7:0] == ($past(flags1_ff) | `IRF_ONES_1))
        else $error("register one read wrong");
    a_read_flags_two: assert property (@(posedge clk) disable iff (rst)
        rd_done && paddr == `IRF_OFF_FLAGS2
            |-> prdata[7:0] == ($past(flags2_ff) | `IRF_ONES_2))
        else $error("register two read wrong");
    a_read_en_one: assert property (@(posedge clk) disable iff (rst)
        rd_done && paddr == `IRF_OFF_EN1
            |-> prdata[7:0] == ($past(en1_ff) | `IRF_ONES_1))
        else $error("enable one read wrong");
    a_read_en_two: assert property (@(posedge clk) disable iff (rst)
        rd_done && paddr == `IRF_OFF_EN2
            |-> prdata[7:0] == ($past(en2_ff) | `IRF_ONES_2))
        else $error("enable two read wrong");
    a_edge_read: assert property (@(posedge clk) disable iff (rst)
        rd_done && paddr == `IRF_OFF_EDGE
            |-> prdata[7:0] == {4'h0, $past(edge_ff)})
        else $error("edge select read wrong");
    a_func_read: assert property (@(posedge clk) disable iff (rst)
        rd_done && paddr == `IRF_OFF_FUNC
            |-> prdata[7:0] == {4'h0, $past(func_ff)})
        else $error("pin function read wrong");

    // control registers and interrupt line
    a_en1_write: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.sel == irf_pkg::IRF_SEL_EN1
            |=> en1_ff == ($past(bus.wdata) & `IRF_MASK_1))
        else $error("enable one write lost");
    a_en2_write: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.sel == irf_pkg::IRF_SEL_EN2
            |=> en2_ff == ($past(bus.wdata) & `IRF_MASK_2))
        else $error("enable two write lost");
    a_edge_write: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.sel == irf_pkg::IRF_SEL_EDGE
            |=> edge_ff == $past(bus.wdata[3:0]))
        else $error("edge select write lost");
    a_func_write: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.sel == irf_pkg::IRF_SEL_FUNC
            |=> func_ff == $past(bus.wdata[3:0]))
        else $error("pin function write lost");
    a_en_rsv: assert property (@(posedge clk) disable iff (rst)
        (en1_ff & ~`IRF_MASK_1) == 8'h00 && (en2_ff & ~`IRF_MASK_2) == 8'h00)
        else $error("reserved enable bit stored");
    a_reset_ctrl: assert property (@(posedge clk)
        rst |=> en1_ff == 8'h00 && en2_ff == 8'h00 && edge_ff == 4'h0 && func_ff == 4'h0)
        else $error("control registers not cleared by reset");
    a_irq_raise_two: assert property (@(posedge clk) disable iff (rst)
        (flags2_ff & en2_ff) != 8'h00 |=> irq)
        else $error("enabled register two flag did not raise interrupt");
    a_irq_low: assert property (@(posedge clk) disable iff (rst)
        (flags1_ff & en1_ff) == 8'h00 && (flags2_ff & en2_ff) == 8'h00 |=> !irq)
        else $error("interrupt high with no enabled flag");
    a_dt_irq: assert property (@(posedge clk) disable iff (rst)
        flags1_ff[`IRF_BIT_DT] && en1_ff[`IRF_BIT_DT] |=> irq)
        else $error("direct transition flag did not raise interrupt");
endmodule
`default_nettype wire

// file: rtl/irf_consts.svh
`ifndef IRF_CONSTS_SVH
`define IRF_CONSTS_SVH

// register byte offsets
`define IRF_OFF_FLAGS1 8'h00
`define IRF_OFF_FLAGS2 8'h04
`define IRF_OFF_EN1 8'h08
`define IRF_OFF_EN2 8'h0c
`define IRF_OFF_EDGE 8'h10
`define IRF_OFF_FUNC 8'h14

// field positions
`define IRF_BIT_DT 7
`define IRF_BIT_RTC 6
`define IRF_BIT_TB 5
`define IRF_PIN_HI 3

// implemented bits and reserved read values
`define IRF_MASK_1 8'hcf
`define IRF_MASK_2 8'h20
`define IRF_ONES_1 8'h30
`define IRF_ONES_2 8'h1f
`define IRF_MASK_PIN 8'h0f

// reset values
`define IRF_RST_FLAGS 8'h00
`define IRF_RST_CTRL 8'h00
`define IRF_RST_SEL 4'h0
`define IRF_RST_PIN 4'hf

`endif

// file: rtl/irf_pkg.sv
package irf_pkg;
    typedef logic [7:0] irf_byte_t;
    typedef enum logic [2:0] {
        IRF_SEL_NONE,
        IRF_SEL_FLAGS1,
        IRF_SEL_FLAGS2,
        IRF_SEL_EN1,
        IRF_SEL_EN2,
        IRF_SEL_EDGE,
        IRF_SEL_FUNC
    } irf_sel_e;
endpackage

// file: rtl/irf_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface irf_bus_if;
    irf_pkg::irf_sel_e sel;
    logic wr;
    irf_pkg::irf_byte_t wdata;
    irf_pkg::irf_byte_t rdata;
    modport slave (output sel, output wr, output wdata, input rdata);
    modport regs (input sel, input wr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: rtl/irf_apb_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "irf_consts.svh"
module irf_apb_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    irf_bus_if.slave bus,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic access;

    // one wait state: answer in the second access cycle
    assign access = psel & penable & ~pready_ff;

    always_comb begin
        case ({paddr[7:2], 2'b00})
            `IRF_OFF_FLAGS1: bus.sel = irf_pkg::IRF_SEL_FLAGS1;
            `IRF_OFF_FLAGS2: bus.sel = irf_pkg::IRF_SEL_FLAGS2;
            `IRF_OFF_EN1: bus.sel = irf_pkg::IRF_SEL_EN1;
            `IRF_OFF_EN2: bus.sel = irf_pkg::IRF_SEL_EN2;
            `IRF_OFF_EDGE: bus.sel = irf_pkg::IRF_SEL_EDGE;
            `IRF_OFF_FUNC: bus.sel = irf_pkg::IRF_SEL_FUNC;
            default: bus.sel = irf_pkg::IRF_SEL_NONE;
        endcase
    end

    // write lands at the edge where pready is sampled high
    assign bus.wr = psel & penable & pready_ff & pwrite;
    assign bus.wdata = pwdata[7:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= access;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= access & (bus.sel == irf_pkg::IRF_SEL_NONE);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_ff <= 32'h0;
        end else if (access & ~pwrite) begin
            prdata_ff <= {24'h0, bus.rdata};
        end else begin
            prdata_ff <= 32'h0;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
endmodule
`default_nettype wire

// file: rtl/irf_pin_edge.sv
`timescale 1ns/1ps
`default_nettype none
`include "irf_consts.svh"
module irf_pin_edge (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] pin,
    input wire logic [3:0] edge_rising,
    input wire logic [3:0] pin_enable,
    output logic [3:0] evt
);
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic [3:0] prev_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= `IRF_RST_PIN;
            sync_ff <= `IRF_RST_PIN;
            prev_ff <= `IRF_RST_PIN;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_pin
            // 1 picks rising, 0 picks falling
            assign evt[i] = pin_enable[i] & (edge_rising[i] ? (sync_ff[i] & ~prev_ff[i])
                                                            : (~sync_ff[i] & prev_ff[i]));
            a_edge_sel_match: assert property (@(posedge clk) disable iff (rst)
                evt[i] |-> (edge_rising[i] ? $rose(sync_ff[i]) : $fell(sync_ff[i])))
                else $error("pin event on wrong edge");
        end
    endgenerate
endmodule
`default_nettype wire

// file: bench/irf_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module irf_cpu_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        err = 1'b0;
    end
    // one apb transfer; returns prdata and latches pslverr into err
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// file: bench/interrupt_request_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_request_flags_tb;
    logic clk, rst, dte, irq, psel, penable, pwrite, pready, pslverr;
    logic [2:0] ev;
    logic [3:0] pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int n_errors = 0;
    int checked = 0;
    irf_top irf_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_direct_transition(ev[0]), .direct_transition_enable(dte),
        .rtc_overflow(ev[1]), .timer_b_overflow(ev[2]), .ext_request_pin(pin), .irq(irq));
    irf_cpu_model irf_cpu_model_inst (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        irf_cpu_model_inst.xfer(1'b1, a, {24'h0, d}, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        irf_cpu_model_inst.xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic fire(input logic [2:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 3'h0;
    endtask
    task automatic irq_is(input logic v);
        idle(2);
        chk({31'h0, irq}, {31'h0, v});
    endtask
    task automatic conclude;
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #20000;
        n_errors++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        ev = 3'h0;
        dte = 1'b0;
        pin = 4'hf;
        idle(3);
        rst <= 1'b0;
        rd(8'h00, 32'h30);
        rd(8'h04, 32'h1f);
        wr(8'h00, 8'hff);
        wr(8'h04, 8'hff);
        rd(8'h00, 32'h30);
        rd(8'h04, 32'h1f);
        rd(8'h18, 32'h0);
        chk({31'h0, irf_cpu_model_inst.err}, 32'h1);
        fire(3'b010);
        idle(1);
        rd(8'h00, 32'h70);
        wr(8'h00, 8'hff);
        rd(8'h00, 32'h70);
        wr(8'h08, 8'h40);
        irq_is(1'b1);
        wr(8'h08, 8'h00);
        irq_is(1'b0);
        fork
            wr(8'h00, 8'h00);
            begin
                idle(3);
                ev <= 3'b010;
                idle(1);
                ev <= 3'h0;
            end
        join
        rd(8'h00, 32'h70);
        wr(8'h00, 8'h00);
        rd(8'h00, 32'h30);
        fire(3'b001);
        idle(1);
        rd(8'h00, 32'h30);
        dte <= 1'b1;
        fire(3'b001);
        idle(1);
        rd(8'h00, 32'hb0);
        wr(8'h08, 8'h80);
        irq_is(1'b1);
        wr(8'h00, 8'h7f);
        irq_is(1'b0);
        rd(8'h00, 32'h30);
        wr(8'h08, 8'h00);
        fire(3'b100);
        idle(1);
        rd(8'h04, 32'h3f);
        wr(8'h0c, 8'h20);
        irq_is(1'b1);
        wr(8'h04, 8'h00);
        irq_is(1'b0);
        rd(8'h04, 32'h1f);
        pin <= 4'h0;
        idle(6);
        rd(8'h00, 32'h30);
        pin <= 4'hf;
        idle(6);
        wr(8'h10, 8'h05);
        wr(8'h14, 8'h0f);
        pin <= 4'h0;
        idle(6);
        rd(8'h00, 32'h3a);
        wr(8'h00, 8'h00);
        pin <= 4'hf;
        idle(6);
        rd(8'h00, 32'h35);
        wr(8'h08, 8'h0f);
        irq_is(1'b1);
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        irq_is(1'b0);
        rd(8'h00, 32'h30);
        conclude();
    end
endmodule
`default_nettype wire
